//--- core/lcc_params.svh
// Offsets, opcodes, field values and reset values of the cursor command block
`ifndef LCC_PARAMS_SVH
`define LCC_PARAMS_SVH

// APB register byte offsets
`define LCC_REG_CMD      8'h00
`define LCC_REG_DATA     8'h04
`define LCC_REG_CFG      8'h08
`define LCC_REG_STATUS   8'h0C
`define LCC_REG_FIX_UP   8'h10
`define LCC_REG_FIX_LO   8'h14

// Opcodes and control codes
`define LCC_OP_CURSOR_SHOW   8'h90
`define LCC_OP_CURSOR_HIDE   8'h91
`define LCC_STEP_PATTERN     6'h23
`define LCC_OP_HOME          8'h8B
`define LCC_OP_GOTO          8'h94
`define LCC_OP_FIX_UPPER     8'h9A
`define LCC_OP_FIX_LOWER     8'h99
`define LCC_OP_FIX_BOTH      8'h9B
`define LCC_OP_FIX_CANCEL    8'h98
`define LCC_OP_STYLE         8'h95
`define LCC_OP_STYLE_OFF     8'h8A
`define LCC_CODE_SRC_TOGGLE  8'h1B
`define LCC_CODE_BACKSPACE   8'h08
`define LCC_CODE_LINE_FEED   8'h0A
`define LCC_CODE_CARR_RET    8'h0D

// Step directions held in the two low opcode bits
`define LCC_DIR_UP     2'h0
`define LCC_DIR_DOWN   2'h1
`define LCC_DIR_RIGHT  2'h2
`define LCC_DIR_LEFT   2'h3

// Last parameter index per opcode
`define LCC_LAST_GOTO   3'h1
`define LCC_LAST_STYLE  3'h0
`define LCC_LAST_FIX1   3'h3
`define LCC_LAST_FIX2   3'h7

// Display mode field values
`define LCC_MODE_CHAR   2'h1
`define LCC_MODE_GFX    2'h2
`define LCC_MODE_MIXED  2'h3

// Attribute bits that may be set: space, line end, underline, reverse, blink
`define LCC_STYLE_MASK  8'h67

// Reset values: 40 columns, 16 rows, display on, character mode, one-byte codes
`define LCC_CFG_RST     20'h3_1028
`define LCC_FIX_ADDR_RST 16'hFFFF

`endif

//--- core/lcc_pkg.sv
// Types shared by the cursor command block
package lcc_pkg;

    typedef enum logic [2:0] {
        LCC_S_IDLE    = 3'h1,
        LCC_S_PARAM   = 3'h2,
        LCC_S_CHAR_HI = 3'h4
    } lcc_state_t;

    typedef struct packed {
        logic       two_byte;
        logic [1:0] mode;
        logic       disp_on;
        logic [7:0] rows;
        logic [7:0] cols;
    } lcc_cfg_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] addr;
        logic [15:0] code;
        logic [7:0]  char_style_cmd;
    } lcc_wr_t;

    typedef struct packed {
        logic       scroll;
        logic [7:0] row;
        logic [7:0] col;
    } lcc_step_t;

    typedef struct packed {
        lcc_state_t  st;
        logic [7:0]  col;
        logic [7:0]  row;
        logic        vis;
        logic        code_source_toggle_cmd;
        logic [7:0]  char_style_cmd;
        logic [7:0]  opc;
        logic [2:0]  pcnt;
        logic [63:0] pbuf;
        logic [7:0]  lo_byte;
        lcc_cfg_t    cfg;
        logic        up_v;
        logic        lo_v;
        logic [15:0] code_up;
        logic [15:0] code_lo;
        logic [15:0] char_style_cmd_up;
        logic [15:0] char_style_cmd_lo;
        logic [31:0] prdata;
        logic        pslverr;
        lcc_wr_t     wr;
        logic        scroll;
        logic        refresh;
    } lcc_regs_t;

endpackage

//--- core/lcc_core.sv
// Cursor and character entry command interpreter with an APB register port
`include "lcc_params.svh"

module lcc_core #(
    parameter int AW = 8
) (
    // Clock, reset and freeze
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              ce,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [AW-1:0]     paddr,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic [31:0]            prdata,
    output logic                   pslverr,
    // Display memory side
    output lcc_pkg::lcc_wr_t       char_wr,
    output logic                   scroll_pulse,
    output logic                   cursor_refresh,
    // Cursor state
    output logic                   cursor_visible,
    output logic [7:0]             cursor_col,
    output logic [7:0]             cursor_row
);

    lcc_pkg::lcc_regs_t q;
    lcc_pkg::lcc_regs_t n;

    logic          acc;
    logic          setup;
    logic [7:0]    addr;
    logic [7:0]    b;
    logic [7:0]    top;
    logic [7:0]    bot;
    logic [7:0]    last_col;
    logic          draw_mode;

    assign acc       = psel && penable && pwrite;
    assign setup     = psel && !penable;
    assign addr      = 8'(paddr);
    assign b         = pwdata[7:0];
    // Fixed rows shrink the editable region from the top and bottom
    assign top       = {7'h00, q.up_v};
    assign bot       = 8'(q.cfg.rows - 8'h01 - {7'h00, q.lo_v});
    assign last_col  = 8'(q.cfg.cols - 8'h01);
    assign draw_mode = q.cfg.disp_on
                       && (q.cfg.mode == `LCC_MODE_CHAR || q.cfg.mode == `LCC_MODE_MIXED);

    // Zero wait states; a low ce stretches the access so no write is missed, but a read set up while ce is low returns the old prdata
    assign pready         = ce;
    assign prdata         = q.prdata;
    assign pslverr        = q.pslverr;
    assign char_wr        = q.wr;
    assign scroll_pulse   = q.scroll;
    assign cursor_refresh = q.refresh;
    assign cursor_visible = q.vis;
    assign cursor_col     = q.col;
    assign cursor_row     = q.row;

    // Positions beyond the screen are compared with >= so they resolve toward the edge
    function automatic lcc_pkg::lcc_step_t step_calc(
        input logic [1:0] dir,
        input logic [7:0] c,
        input logic [7:0] r,
        input logic [7:0] lc,
        input logic [7:0] t,
        input logic [7:0] bt
    );
        lcc_pkg::lcc_step_t s;
        s.scroll = 1'b0;
        s.col    = c;
        s.row    = r;
        case (dir)
            `LCC_DIR_UP:
            begin
                if (r > t)
                    s.row = 8'(r - 8'h01);
            end
            `LCC_DIR_DOWN:
            begin
                if (r >= bt)
                    s.scroll = 1'b1;
                else
                    s.row = 8'(r + 8'h01);
            end
            `LCC_DIR_RIGHT:
            begin
                if (c >= lc)
                begin
                    s.col = 8'h00;
                    if (r >= bt)
                        s.scroll = 1'b1;
                    else
                        s.row = 8'(r + 8'h01);
                end
                else
                    s.col = 8'(c + 8'h01);
            end
            default:
            begin
                if (c != 8'h00)
                    s.col = 8'(c - 8'h01);
                else if (r > t)
                begin
                    s.col = lc;
                    s.row = 8'(r - 8'h01);
                end
            end
        endcase
        return s;
    endfunction

    always_comb
    begin
        logic               step_req;
        logic [1:0]         step_dir;
        logic               put_req;
        logic [15:0]        put_code;
        logic               is_ctrl;
        lcc_pkg::lcc_step_t s;
        step_req = 1'b0;
        step_dir = `LCC_DIR_UP;
        put_req  = 1'b0;
        put_code = 16'h0000;
        is_ctrl  = 1'b0;
        s        = '0;
        n        = q;
        if (ce)
        begin
            n.wr.valid = 1'b0;
            n.scroll   = 1'b0;
            n.refresh  = 1'b0;
            if (setup)
            begin
                n.pslverr = 1'b0;
                n.prdata  = 32'h0000_0000;
                if (addr == `LCC_REG_CMD || addr == `LCC_REG_DATA)
                    n.prdata = 32'h0000_0000;
                else if (addr == `LCC_REG_CFG)
                    n.prdata = 32'(q.cfg);
                else if (addr == `LCC_REG_STATUS)
                    n.prdata = {q.char_style_cmd, 3'h0, q.lo_v, q.up_v,
                                q.st != lcc_pkg::LCC_S_IDLE, q.code_source_toggle_cmd, q.vis, q.row, q.col};
                else if (addr == `LCC_REG_FIX_UP)
                    n.prdata = {q.char_style_cmd_up, q.code_up};
                else if (addr == `LCC_REG_FIX_LO)
                    n.prdata = {q.char_style_cmd_lo, q.code_lo};
                else
                    n.pslverr = 1'b1;
            end
            if (acc && addr == `LCC_REG_CFG)
                n.cfg = pwdata[19:0];
            else if (acc && (addr == `LCC_REG_CMD || addr == `LCC_REG_DATA))
            begin
                case (q.st)
                    lcc_pkg::LCC_S_PARAM:
                    begin
                        n.pbuf[{q.pcnt, 3'h0} +: 8] = b;
                        n.pcnt = 3'(q.pcnt + 3'h1);
                        if ((q.opc == `LCC_OP_GOTO && q.pcnt == `LCC_LAST_GOTO)
                            || (q.opc == `LCC_OP_STYLE && q.pcnt == `LCC_LAST_STYLE)
                            || (q.opc == `LCC_OP_FIX_BOTH && q.pcnt == `LCC_LAST_FIX2)
                            || (q.opc != `LCC_OP_FIX_BOTH && q.pcnt == `LCC_LAST_FIX1))
                        begin
                            n.st = lcc_pkg::LCC_S_IDLE;
                            if (q.opc == `LCC_OP_GOTO)
                            begin
                                n.col = n.pbuf[7:0];
                                n.row = n.pbuf[15:8];
                            end
                            else if (q.opc == `LCC_OP_STYLE)
                                n.char_style_cmd = n.pbuf[7:0] & `LCC_STYLE_MASK;
                            else if (q.opc == `LCC_OP_FIX_UPPER)
                            begin
                                n.code_up = n.pbuf[15:0];
                                n.char_style_cmd_up = n.pbuf[31:16];
                                n.up_v    = 1'b1;
                            end
                            else if (q.opc == `LCC_OP_FIX_LOWER)
                            begin
                                n.code_lo = n.pbuf[15:0];
                                n.char_style_cmd_lo = n.pbuf[31:16];
                                n.lo_v    = 1'b1;
                            end
                            else
                            begin
                                n.code_up = n.pbuf[15:0];
                                n.code_lo = n.pbuf[31:16];
                                n.char_style_cmd_up = n.pbuf[47:32];
                                n.char_style_cmd_lo = n.pbuf[63:48];
                                n.up_v    = 1'b1;
                                n.lo_v    = 1'b1;
                            end
                        end
                    end
                    lcc_pkg::LCC_S_CHAR_HI:
                    begin
                        // High byte of a two-byte code comes on the data port only
                        if (addr == `LCC_REG_DATA)
                        begin
                            put_req  = 1'b1;
                            put_code = {b, q.lo_byte};
                            n.st     = lcc_pkg::LCC_S_IDLE;
                        end
                    end
                    default:
                    begin
                        is_ctrl = b == `LCC_CODE_SRC_TOGGLE || b == `LCC_CODE_BACKSPACE
                                  || b == `LCC_CODE_LINE_FEED || b == `LCC_CODE_CARR_RET;
                        if (addr != `LCC_REG_CMD)
                            n.st = lcc_pkg::LCC_S_IDLE;
                        else if (b == `LCC_CODE_SRC_TOGGLE)
                            n.code_source_toggle_cmd = !q.code_source_toggle_cmd;
                        else if (b == `LCC_CODE_BACKSPACE)
                        begin
                            step_req = 1'b1;
                            step_dir = `LCC_DIR_LEFT;
                        end
                        else if (b == `LCC_CODE_LINE_FEED)
                        begin
                            step_req = 1'b1;
                            step_dir = `LCC_DIR_DOWN;
                        end
                        else if (b == `LCC_CODE_CARR_RET)
                            n.col = 8'h00;
                        else if ((q.code_source_toggle_cmd || !b[7]) && !is_ctrl)
                        begin
                            if (q.cfg.two_byte)
                            begin
                                n.lo_byte = b;
                                n.st      = lcc_pkg::LCC_S_CHAR_HI;
                            end
                            else
                            begin
                                put_req  = 1'b1;
                                put_code = {8'h00, b};
                            end
                        end
                        else if (b == `LCC_OP_CURSOR_SHOW)
                        begin
                            n.vis     = 1'b1;
                            n.refresh = draw_mode;
                        end
                        else if (b == `LCC_OP_CURSOR_HIDE)
                        begin
                            n.vis     = 1'b0;
                            n.refresh = draw_mode;
                        end
                        else if (b[7:2] == `LCC_STEP_PATTERN)
                        begin
                            step_req = 1'b1;
                            step_dir = b[1:0];
                        end
                        else if (b == `LCC_OP_HOME)
                        begin
                            n.col = 8'h00;
                            n.row = top;
                        end
                        else if (b == `LCC_OP_FIX_CANCEL)
                        begin
                            n.up_v = 1'b0;
                            n.lo_v = 1'b0;
                        end
                        else if (b == `LCC_OP_STYLE_OFF)
                            n.char_style_cmd = 8'h00;
                        else if (b == `LCC_OP_GOTO || b == `LCC_OP_STYLE
                                 || b == `LCC_OP_FIX_UPPER || b == `LCC_OP_FIX_LOWER
                                 || b == `LCC_OP_FIX_BOTH)
                        begin
                            n.opc  = b;
                            n.pcnt = 3'h0;
                            n.st   = lcc_pkg::LCC_S_PARAM;
                        end
                    end
                endcase
            end
            if (put_req)
            begin
                n.wr.valid = 1'b1;
                n.wr.addr  = 16'(16'(q.row) * 16'(q.cfg.cols) + 16'(q.col));
                n.wr.code  = put_code;
                n.wr.char_style_cmd  = q.char_style_cmd;
                if (draw_mode)
                begin
                    step_req = 1'b1;
                    step_dir = `LCC_DIR_RIGHT;
                end
            end
            if (step_req)
            begin
                s        = step_calc(step_dir, q.col, q.row, last_col, top, bot);
                n.col    = s.col;
                n.row    = s.row;
                n.scroll = s.scroll;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            q         <= '0;
            q.st      <= lcc_pkg::LCC_S_IDLE;
            q.vis     <= 1'b1;
            q.cfg     <= `LCC_CFG_RST;
            q.code_up <= `LCC_FIX_ADDR_RST;
            q.code_lo <= `LCC_FIX_ADDR_RST;
            q.char_style_cmd_up <= `LCC_FIX_ADDR_RST;
            q.char_style_cmd_lo <= `LCC_FIX_ADDR_RST;
        end
        else
            q <= n;
    end

    logic cmd_take;
    assign cmd_take = ce && acc && addr == `LCC_REG_CMD && q.st == lcc_pkg::LCC_S_IDLE;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_show_sets_vis: assert property (cmd_take && b == `LCC_OP_CURSOR_SHOW |=> q.vis)
        else $error("show command did not set visible");
    a_hide_clr_vis: assert property (cmd_take && b == `LCC_OP_CURSOR_HIDE |=> !q.vis)
        else $error("hide command did not clear visible");
    a_up_top_hold: assert property (cmd_take && b == {`LCC_STEP_PATTERN, `LCC_DIR_UP}
        && q.row <= top |=> $stable(q.row) && $stable(q.col))
        else $error("up step moved off top row");
    a_down_bot_scroll: assert property (cmd_take && b == {`LCC_STEP_PATTERN, `LCC_DIR_DOWN}
        && q.row == bot |=> q.scroll && $stable(q.row) && $stable(q.col) ##1 !q.scroll)
        else $error("down step at bottom did not scroll");
    a_right_wrap: assert property (cmd_take && b == {`LCC_STEP_PATTERN, `LCC_DIR_RIGHT}
        && q.col == last_col && q.row < bot |=> q.col == 8'h00 && q.row == $past(q.row) + 8'h01)
        else $error("right step did not wrap");
    a_left_wrap: assert property (cmd_take && b == {`LCC_STEP_PATTERN, `LCC_DIR_LEFT}
        && q.col == 8'h00 && q.row > top |=> q.col == last_col && q.row == $past(q.row) - 8'h01)
        else $error("left step did not wrap back");
    a_home_region: assert property (cmd_take && b == `LCC_OP_HOME
        |=> q.col == 8'h00 && q.row == top)
        else $error("home landed outside editable region");
    a_esc_toggle: assert property (cmd_take && b == `LCC_CODE_SRC_TOGGLE
        |=> q.code_source_toggle_cmd != $past(q.code_source_toggle_cmd) && !q.wr.valid)
        else $error("escape did not toggle source");
    a_char_gfx_still: assert property (cmd_take && !b[7] && !q.cfg.two_byte && !draw_mode
        && b != `LCC_CODE_SRC_TOGGLE && b != `LCC_CODE_BACKSPACE
        && b != `LCC_CODE_LINE_FEED && b != `LCC_CODE_CARR_RET
        |=> q.wr.valid && $stable(q.col) && $stable(q.row))
        else $error("character moved cursor outside drawing mode");
    a_cancel_fixed: assert property (cmd_take && b == `LCC_OP_FIX_CANCEL
        |=> !q.up_v && !q.lo_v)
        else $error("cancel left a fixed row valid");

    c_goto_done: cover property (q.st == lcc_pkg::LCC_S_PARAM && q.opc == `LCC_OP_GOTO
        ##1 q.st == lcc_pkg::LCC_S_IDLE);
    c_scroll: cover property (q.scroll);
    c_two_byte_char: cover property (q.st == lcc_pkg::LCC_S_CHAR_HI ##1 q.wr.valid);

endmodule

//--- testbench/lcc_host.sv
// Host model: APB master that carries command and data bytes to the block
module lcc_host (
    // Clock
    input  wire logic        pclk,
    // APB request
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    // APB answer
    input  wire logic        pready,
    input  wire logic [31:0] prdata,
    input  wire logic        pslverr
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'hFF;
        pwdata  = 32'hA5A5_A5A5;
    end

    // Request held until pready is seen high at an edge; the wait is bounded
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic err, output logic hung);
        int n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 200);
        rd      = prdata;
        err     = pslverr;
        hung    = (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
        // Released lines must not keep showing the old request
        paddr   <= ~a;
        pwdata  <= ~d;
    endtask
endmodule

//--- testbench/lcd_cursor_and_char_entry_commands_tb.sv
// Self-checking bench for the cursor and character entry command block
`include "lcc_params.svh"
module lcd_cursor_and_char_entry_commands_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic             pclk;
    logic             presetn;
    logic             ce;
    logic             psel;
    logic             penable;
    logic             pwrite;
    logic [7:0]       paddr;
    logic [31:0]      pwdata;
    logic             pready;
    logic [31:0]      prdata;
    logic             pslverr;
    lcc_pkg::lcc_wr_t char_wr;
    lcc_pkg::lcc_wr_t w;
    logic             scroll_pulse;
    logic             cursor_refresh;
    logic             cursor_visible;
    logic [7:0]       cursor_col;
    logic [7:0]       cursor_row;
    logic             sc;
    logic             rf;
    logic [31:0]      rd;
    logic             err;
    logic [7:0]       q[$];
    int               fail_count;
    int               samples_checked;

    // Step table: opcode, start col, start row, end col, end row, scroll
    localparam logic [47:0] steps_tab [0:10] = '{
        48'h8C05_0005_0000, 48'h8C05_0305_0200, 48'h8D05_0305_0400,
        48'h8D05_0F05_0F01, 48'h0A05_0F05_0F01, 48'h8E27_0300_0400,
        48'h8E27_0F00_0F01, 48'h8F00_0327_0200, 48'h0800_0000_0000,
        48'h0804_0403_0400, 48'h0D07_0400_0400};

    lcc_core #(.AW(8)) uut (
        .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .char_wr(char_wr),
        .scroll_pulse(scroll_pulse), .cursor_refresh(cursor_refresh),
        .cursor_visible(cursor_visible), .cursor_col(cursor_col), .cursor_row(cursor_row));

    lcc_host host (
        .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));

    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("FAIL at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_wr(input logic [15:0] a, input logic [15:0] c, input logic [7:0] s);
        chk({15'h0, w.valid, w.addr}, {16'h0001, a});
        chk({w.code, 8'h00, w.char_style_cmd}, {c, 8'h00, s});
    endtask

    // Pulses last one cycle, so they are captured just after the taking edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        logic hung;
        host.xfer(wr, a, d, rd, err, hung);
        #1;
        w  = char_wr;
        sc = scroll_pulse;
        rf = cursor_refresh;
        if (hung === 1'b1)
        begin
            fail_count++;
            report_and_stop();
        end
    endtask

    task automatic put(input logic [7:0] b);
        bus(1'b1, `LCC_REG_CMD, {24'h0, b});
    endtask

    task automatic send();
        foreach (q[i])
            put(q[i]);
    endtask

    task automatic pos(input logic [7:0] c, input logic [7:0] r);
        q = '{`LCC_OP_GOTO, c, r};
        send();
    endtask

    task automatic at_pos(input logic [7:0] c, input logic [7:0] r);
        chk({16'h0, cursor_col, cursor_row}, {16'h0, c, r});
    endtask

    task automatic t_reset();
        chk({31'h0, cursor_visible}, 32'h1);
        at_pos(8'h00, 8'h00);
        bus(1'b0, `LCC_REG_STATUS, 32'h0);
        chk(rd, 32'h0001_0000);
        bus(1'b0, `LCC_REG_CFG, 32'h0);
        chk(rd, 32'h0003_1028);
        bus(1'b0, 8'h18, 32'h0);
        chk({31'h0, err}, 32'h1);
        $display("reset test done");
    endtask

    task automatic t_show();
        @(posedge pclk);
        ce <= 1'b0;
        fork
            put(`LCC_OP_CURSOR_HIDE);
            begin
                repeat (4) @(posedge pclk);
                ce <= 1'b1;
            end
        join
        chk({30'h0, cursor_visible, rf}, 32'h1);
        pos(8'h05, 8'h03);
        put(8'h8D);
        at_pos(8'h05, 8'h04);
        pos(8'h32, 8'h14);
        at_pos(8'h32, 8'h14);
        put(8'h41);
        chk({16'h0, w.addr}, 32'h0000_0352);
        put(`LCC_OP_CURSOR_SHOW);
        chk({30'h0, cursor_visible, rf}, 32'h3);
        $display("show test done");
    endtask

    task automatic t_steps();
        foreach (steps_tab[i])
        begin
            pos(steps_tab[i][39:32], steps_tab[i][31:24]);
            put(steps_tab[i][47:40]);
            chk({8'h0, cursor_col, cursor_row, 7'h0, sc}, {8'h0, steps_tab[i][23:0]});
        end
        $display("step test done");
    endtask

    task automatic t_fixed();
        q = '{`LCC_OP_FIX_UPPER, 8'h34, 8'h12, 8'hFF, 8'hFF, `LCC_OP_HOME};
        send();
        at_pos(8'h00, 8'h01);
        bus(1'b0, `LCC_REG_FIX_UP, 32'h0);
        chk(rd, 32'hFFFF_1234);
        put(8'h8C);
        at_pos(8'h00, 8'h01);
        q = '{`LCC_OP_FIX_CANCEL, `LCC_OP_HOME};
        send();
        at_pos(8'h00, 8'h00);
        q = '{`LCC_OP_FIX_BOTH, 8'h11, 8'h22, 8'h33, 8'h44, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
        send();
        bus(1'b0, `LCC_REG_FIX_UP, 32'h0);
        chk(rd, 32'hFFFF_2211);
        bus(1'b0, `LCC_REG_FIX_LO, 32'h0);
        chk(rd, 32'hFFFF_4433);
        pos(8'h05, 8'h0E);
        put(8'h8D);
        chk({23'h0, cursor_row, sc}, 32'h0000_001D);
        q = '{`LCC_OP_FIX_CANCEL, `LCC_OP_FIX_LOWER, 8'h66, 8'h55, 8'hFF, 8'hFF};
        send();
        bus(1'b0, `LCC_REG_STATUS, 32'h0);
        chk(rd & 32'h0018_0000, 32'h0010_0000);
        bus(1'b0, `LCC_REG_FIX_LO, 32'h0);
        chk(rd, 32'hFFFF_5566);
        put(`LCC_OP_FIX_CANCEL);
        $display("fixed row test done");
    endtask

    task automatic t_chars();
        q = '{`LCC_OP_STYLE, 8'hFF, `LCC_OP_GOTO, 8'h03, 8'h02, 8'h41};
        send();
        chk_wr(16'd83, 16'h0041, 8'h67);
        at_pos(8'h04, 8'h02);
        q = '{8'h42, `LCC_OP_STYLE_OFF, 8'h43};
        send();
        chk_wr(16'd85, 16'h0043, 8'h00);
        q = '{`LCC_CODE_SRC_TOGGLE, 8'hC1};
        send();
        chk_wr(16'd86, 16'h00C1, 8'h00);
        put(`LCC_CODE_CARR_RET);
        chk({w.valid, 23'h0, cursor_col}, 32'h0);
        put(`LCC_CODE_SRC_TOGGLE);
        put(8'hC1);
        chk({31'h0, w.valid}, 32'h0);
        q = '{`LCC_OP_GOTO, 8'h27, 8'h0F, 8'h44};
        send();
        chk_wr(16'd639, 16'h0044, 8'h00);
        chk({23'h0, cursor_col, sc}, 32'h1);
        $display("character test done");
    endtask

    task automatic t_modes();
        bus(1'b1, `LCC_REG_CFG, 32'h0005_1028);
        q = '{`LCC_OP_GOTO, 8'h03, 8'h02, 8'h41, `LCC_OP_CURSOR_SHOW};
        send();
        chk({31'h0, rf}, 32'h0);
        at_pos(8'h03, 8'h02);
        bus(1'b1, `LCC_REG_CFG, 32'h0002_1028);
        put(8'h41);
        chk_wr(16'd83, 16'h0041, 8'h00);
        at_pos(8'h03, 8'h02);
        bus(1'b1, `LCC_REG_CFG, 32'h000B_1028);
        put(8'h21);
        chk({31'h0, w.valid}, 32'h0);
        bus(1'b1, `LCC_REG_DATA, 32'h0000_0022);
        chk_wr(16'd83, 16'h2221, 8'h00);
        bus(1'b1, `LCC_REG_CFG, 32'h0007_1028);
        put(`LCC_OP_CURSOR_HIDE);
        chk({31'h0, rf}, 32'h1);
        $display("mode test done");
    endtask

    initial
    begin
        presetn         = 1'b0;
        ce              = 1'b1;
        fail_count      = 0;
        samples_checked = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_show();
        t_steps();
        t_fixed();
        t_chars();
        t_modes();
        report_and_stop();
    end
endmodule
